/* File: design/dcdm_ms_tick.sv */
// millisecond tick generator
`timescale 1ns/10ps
module dcdm_ms_tick
    import dcdm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 125000
)
(
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    dcdm_tick_st_t st_ff;
    dcdm_tick_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.count >= TICK_CYCLES - 1)
        begin
            nxt_st.count = 32'h0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.count = st_ff.count + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;
endmodule : dcdm_ms_tick

/* File: design/dcdm_pair_cmp.sv */
// offset, deadband and discrepancy timer of one channel pair
`timescale 1ns/10ps
module dcdm_pair_cmp
    import dcdm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    dcdm_pair_if.cmp pif
);
    dcdm_pair_st_t st_ff;
    dcdm_pair_st_t nxt_st;
    logic signed [16:0] sum;
    logic signed [15:0] b_adj;
    logic signed [16:0] diff;
    logic [16:0] mag;
    logic over;

    always_comb
    begin
        // offset moves the second member toward the first
        sum = {pif.b[15], pif.b} + {pif.offs[15], pif.offs};
        if (sum[16] != sum[15])
            b_adj = sum[16] ? 16'sh8000 : 16'sh7FFF;
        else
            b_adj = sum[15:0];
        diff = {pif.a[15], pif.a} - {b_adj[15], b_adj};
        mag = diff[16] ? (~diff + 17'h1) : diff;
        // single pairs never compare
        over = pif.equiv && (mag > {2'h0, pif.dband});
        nxt_st = st_ff;
        nxt_st.over = over;
        if (!over)
        begin
            nxt_st.timer = 16'h0;
            nxt_st.fault = 1'b0;
        end
        else if (pif.dtime == 16'h0)
        begin
            nxt_st.fault = 1'b0;
        end
        else if (pif.tick && !st_ff.fault)
        begin
            // fault only once the full time has passed, hence one tick more
            if (st_ff.timer >= pif.dtime)
                nxt_st.fault = 1'b1;
            else
                nxt_st.timer = st_ff.timer + 16'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pif.over = st_ff.over;
    assign pif.fault = st_ff.fault;

    a_zero_time_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pif.dtime == 16'h0) |=> !st_ff.fault)
        else $error("fault raised with zero discrepancy time");
    a_single_no_cmp: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pif.equiv |=> !st_ff.over && !st_ff.fault)
        else $error("single pair was compared");
    a_fault_after_time: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(st_ff.fault) |-> $past(st_ff.over) && (st_ff.timer == $past(pif.dtime)))
        else $error("fault raised before discrepancy time");
    a_timer_restart: assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_ff.over |-> (st_ff.timer == 16'h0) && !st_ff.fault)
        else $error("timer not restarted inside deadband");
    c_fault_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(st_ff.fault));
endmodule : dcdm_pair_cmp

/* File: design/dcdm_top.sv */
// dual channel discrepancy monitor with apb register slave
//
// Operation
// - single pair: two independent channels, no comparison
// - equivalent pair: compare, error when no agreement within discrepancy time
// - discrepancy time 0 to 65530 ms, 10 ms steps; the code counts it in 1 ms steps, one per tick
// - discrepancy time zero never raises a fault
// - deadband 0 to 32767 units, unsigned
// - fault when difference stays beyond deadband longer than discrepancy time
// - signed pair offset -32768 to 32767 units
// - offset applied from channel 1 to 0 and 3 to 2
// - input error held for latch time, 0 to 65530 ms, default 1000
// - brief input fault still reported for the whole latch time
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "dcdm_params.svh"
module dcdm_top
    import dcdm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `DCDM_TICK_NS / `DCDM_CLK_NS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0][15:0] ch_value,
    input wire logic [3:0] chan_err,
    output logic [3:0] err_latched,
    output logic [1:0] disc_fault,
    output logic irq
);
    // ------------------------------------------------------------
    // state and reset value
    // ------------------------------------------------------------
    localparam dcdm_top_st_t ST_RST = '{
        equiv: `DCDM_RST_CTRL,
        dtime: {2{`DCDM_RST_DTIME}},
        dband: {2{`DCDM_RST_DBAND}},
        offs: {2{`DCDM_RST_OFFS}},
        ltime: `DCDM_RST_LTIME,
        mask: `DCDM_RST_MASK,
        default: '0
    };

    dcdm_top_st_t st_ff;
    dcdm_top_st_t nxt_st;
    logic tick_w;
    logic [1:0] fault_w;
    logic [1:0] over_w;
    logic [3:0] err_now;
    logic [5:0] events;
    logic [5:0] clr_bits;
    logic [31:0] rd_data;
    logic [15:0] wd_time;
    logic unmapped;
    logic access;
    logic handshake;
    logic wr_en;

    // ------------------------------------------------------------
    // millisecond time base and the two pairs
    // ------------------------------------------------------------
    dcdm_ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_w)
    );

    for (genvar p = 0; p < 2; p++)
    begin : g_pair
        dcdm_pair_if pif ();
        // first member is the even channel, second the odd one
        assign pif.a = ch_value[2 * p];
        assign pif.b = ch_value[2 * p + 1];
        assign pif.offs = st_ff.offs[p];
        assign pif.dband = st_ff.dband[p];
        assign pif.dtime = st_ff.dtime[p];
        assign pif.equiv = st_ff.equiv[p];
        assign pif.tick = tick_w;
        assign fault_w[p] = pif.fault;
        assign over_w[p] = pif.over;
        dcdm_pair_cmp u_cmp (
            .pclk(pclk),
            .presetn(presetn),
            .pif(pif.cmp)
        );
    end

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rd_data = 32'h0;
        unmapped = 1'b0;
        case (paddr)
            `DCDM_ADDR_CTRL: rd_data = {30'h0, st_ff.equiv};
            `DCDM_ADDR_DTIME0: rd_data = {16'h0, st_ff.dtime[0]};
            `DCDM_ADDR_DTIME1: rd_data = {16'h0, st_ff.dtime[1]};
            `DCDM_ADDR_DBAND0: rd_data = {17'h0, st_ff.dband[0]};
            `DCDM_ADDR_DBAND1: rd_data = {17'h0, st_ff.dband[1]};
            `DCDM_ADDR_OFFS0: rd_data = {16'h0, st_ff.offs[0]};
            `DCDM_ADDR_OFFS1: rd_data = {16'h0, st_ff.offs[1]};
            `DCDM_ADDR_LTIME: rd_data = {16'h0, st_ff.ltime};
            `DCDM_ADDR_STAT: rd_data = {26'h0, st_ff.status};
            `DCDM_ADDR_MASK: rd_data = {26'h0, st_ff.mask};
            `DCDM_ADDR_STATE: rd_data = {24'h0, over_w, st_ff.fault_d, st_ff.err_lat};
            default: unmapped = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        access = psel && penable;
        handshake = access && st_ff.pready;
        wr_en = handshake && pwrite && !st_ff.pslverr;
        // times beyond the top of the range are clamped, not wrapped
        if (pwdata[15:0] > `DCDM_TIME_MAX)
            wd_time = `DCDM_TIME_MAX;
        else
            wd_time = pwdata[15:0];

        // one wait state keeps prdata and pready straight from flops
        nxt_st.pready = access && !st_ff.pready;
        nxt_st.pslverr = access && !st_ff.pready && unmapped;
        if (access && !st_ff.pready && !pwrite)
            nxt_st.prdata = rd_data;

        if (wr_en)
        begin
            case (paddr)
                `DCDM_ADDR_CTRL: nxt_st.equiv = pwdata[1:0];
                `DCDM_ADDR_DTIME0: nxt_st.dtime[0] = wd_time;
                `DCDM_ADDR_DTIME1: nxt_st.dtime[1] = wd_time;
                `DCDM_ADDR_DBAND0: nxt_st.dband[0] = pwdata[14:0];
                `DCDM_ADDR_DBAND1: nxt_st.dband[1] = pwdata[14:0];
                `DCDM_ADDR_OFFS0: nxt_st.offs[0] = pwdata[15:0];
                `DCDM_ADDR_OFFS1: nxt_st.offs[1] = pwdata[15:0];
                `DCDM_ADDR_LTIME: nxt_st.ltime = wd_time;
                `DCDM_ADDR_MASK: nxt_st.mask = pwdata[5:0];
                default: nxt_st.mask = st_ff.mask;
            endcase
        end

        // a pair fault is an input error of both its channels
        err_now = chan_err | {fault_w[1], fault_w[1], fault_w[0], fault_w[0]};
        for (int i = 0; i < 4; i++)
        begin
            if (err_now[i])
                nxt_st.lcnt[i] = st_ff.ltime;
            else if (tick_w && (st_ff.lcnt[i] != 16'h0))
                nxt_st.lcnt[i] = st_ff.lcnt[i] - 16'h1;
            // a one-cycle error still holds for the whole count
            nxt_st.err_lat[i] = err_now[i] || (nxt_st.lcnt[i] != 16'h0);
        end
        nxt_st.err_d = err_now;
        nxt_st.fault_d = fault_w;

        // clear only what was returned; a new event always wins
        events = {err_now & ~st_ff.err_d, fault_w & ~st_ff.fault_d};
        if (handshake && !pwrite && (paddr == `DCDM_ADDR_STAT))
            clr_bits = st_ff.prdata[5:0];
        else
            clr_bits = 6'h0;
        nxt_st.status = (st_ff.status & ~clr_bits) | events;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_ff <= ST_RST;
        else
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign err_latched = st_ff.err_lat;
    assign disc_fault = st_ff.fault_d;
    assign irq = st_ff.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_latch_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (chan_err[0] && (st_ff.ltime != 16'h0))
        |=> (st_ff.lcnt[0] == $past(st_ff.ltime)) && err_latched[0])
        else $error("latch count not loaded on input error");
    a_brief_fault_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        (chan_err[1] && (st_ff.ltime > 16'h2) && !tick_w)
        |=> err_latched[1] [*2])
        else $error("brief input error not held");
    a_time_range: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_ff.dtime[0] <= `DCDM_TIME_MAX) && (st_ff.dtime[1] <= `DCDM_TIME_MAX)
        && (st_ff.ltime <= `DCDM_TIME_MAX))
        else $error("time setting beyond range");
    a_pair_err_both: assert property (
        @(posedge pclk) disable iff (!presetn)
        fault_w[1] |=> err_latched[2] && err_latched[3] && disc_fault[1])
        else $error("pair fault not reported on both channels");
    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq == |(st_ff.status & st_ff.mask))
        else $error("interrupt does not follow masked status");
    a_ready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle after access");
    c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_latch_end: cover property (@(posedge pclk) disable iff (!presetn) $fell(err_latched[0]));
    c_status_read: cover property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && (paddr == `DCDM_ADDR_STAT));
endmodule : dcdm_top

/* File: include/dcdm_pair_if.sv */
// settings, samples and results of one channel pair
`timescale 1ns/10ps
interface dcdm_pair_if;
    logic signed [15:0] a;
    logic signed [15:0] b;
    logic signed [15:0] offs;
    logic [14:0] dband;
    logic [15:0] dtime;
    logic equiv;
    logic tick;
    logic over;
    logic fault;
    modport cmp (input a, b, offs, dband, dtime, equiv, tick, output over, fault);
    modport ctl (output a, b, offs, dband, dtime, equiv, tick, input over, fault);
endinterface : dcdm_pair_if

/* File: include/dcdm_params.svh */
// register offsets, reset values and timing constants of the discrepancy monitor
`ifndef DCDM_PARAMS_SVH
`define DCDM_PARAMS_SVH
`define DCDM_ADDR_CTRL 8'h00
`define DCDM_ADDR_DTIME0 8'h04
`define DCDM_ADDR_DTIME1 8'h08
`define DCDM_ADDR_DBAND0 8'h0C
`define DCDM_ADDR_DBAND1 8'h10
`define DCDM_ADDR_OFFS0 8'h14
`define DCDM_ADDR_OFFS1 8'h18
`define DCDM_ADDR_LTIME 8'h1C
`define DCDM_ADDR_STAT 8'h20
`define DCDM_ADDR_MASK 8'h24
`define DCDM_ADDR_STATE 8'h28
`define DCDM_STAT_DISC_LSB 0
`define DCDM_STAT_ERR_LSB 2
`define DCDM_RST_CTRL 2'h0
`define DCDM_RST_DTIME 16'h0000
`define DCDM_RST_DBAND 15'h0000
`define DCDM_RST_OFFS 16'h0000
`define DCDM_RST_LTIME 16'h03E8
`define DCDM_RST_MASK 6'h00
`define DCDM_TIME_MAX 16'hFFFA
`define DCDM_TICK_NS 1000000
`define DCDM_CLK_NS 8
`endif

/* File: include/dcdm_pkg.sv */
// types of the discrepancy monitor
package dcdm_pkg;
    typedef struct packed {
        logic [15:0] timer;
        logic over;
        logic fault;
    } dcdm_pair_st_t;
    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } dcdm_tick_st_t;
    typedef struct packed {
        logic [1:0] equiv;
        logic [1:0][15:0] dtime;
        logic [1:0][14:0] dband;
        logic [1:0][15:0] offs;
        logic [15:0] ltime;
        logic [5:0] status;
        logic [5:0] mask;
        logic [3:0][15:0] lcnt;
        logic [3:0] err_lat;
        logic [3:0] err_d;
        logic [1:0] fault_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } dcdm_top_st_t;
endpackage : dcdm_pkg

/* File: tb/dcdm_ctrl_model.sv */
// safety controller model that samples latched channel errors once per update
`timescale 1ns/10ps
module dcdm_ctrl_model
    import dcdm_pkg::*;
#(
    parameter int UPDATE = 7
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] err_latched,
    input wire logic clear,
    output logic [3:0] seen_ff
);
    int cnt_ff;
    // sparse sampling: a short error is seen only if the latch stretches it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 0;
            seen_ff <= 4'h0;
        end
        else
        begin
            cnt_ff <= (cnt_ff == UPDATE - 1) ? 0 : cnt_ff + 1;
            if (clear)
                seen_ff <= 4'h0;
            else if (cnt_ff == 0)
                seen_ff <= seen_ff | err_latched;
        end
    end
endmodule : dcdm_ctrl_model

/* File: tb/dual_channel_discrepancy_monitor_test.sv */
// self-checking bench of the discrepancy monitor
`timescale 1ns/10ps
`include "dcdm_params.svh"
module dual_channel_discrepancy_monitor_test
    import dcdm_pkg::*;
;
    typedef struct {logic [32:0] exp; logic [32:0] care;} dcdm_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, clr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lfsr;
    logic [15:0] base;
    logic [3:0][15:0] ch_value;
    logic [3:0] chan_err, err_latched, seen;
    logic [1:0] disc_fault;
    dcdm_note_t note_q[$];
    int bad_count, total_checks;

    dcdm_top #(.TICK_CYCLES(10)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ch_value, .chan_err, .err_latched,
        .disc_fault, .irq);
    dcdm_ctrl_model #(.UPDATE(7)) ctl (.pclk, .presetn, .err_latched, .clear(clr),
        .seen_ff(seen));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] got, input logic [32:0] want);
        total_checks++;
        if (got !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    function automatic logic [31:0] nxt_lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt_lfsr

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // --------------------------------
    // apb master
    // --------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 1;
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
        begin
            bad_count++;
            $display("wrong value at %0t: no pready", $time);
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] c);
        note_q.push_back('{e, c});
        apb(1'b0, a, 32'h0);
    endtask : rd

    always @(posedge pclk)
    begin
        dcdm_note_t nt;
        if (psel && penable && pready && !pwrite)
        begin
            nt = note_q.pop_front();
            check({pslverr, prdata} & nt.care, nt.exp);
        end
    end

    // --------------------------------
    // scenarios
    // --------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ch_value = '0;
        chan_err = 4'h0;
        clr = 1'b0;
        lfsr = 32'hF904C9D4;
        cyc(2);
        presetn <= 1'b1;
        rd(`DCDM_ADDR_LTIME, 33'h0_0000_03E8, '1);
        rd(8'hFC, 33'h1_0000_0000, '1);
        wr(`DCDM_ADDR_LTIME, 32'h0000_FFFF);
        rd(`DCDM_ADDR_LTIME, 33'h0_0000_FFFA, '1);
        wr(`DCDM_ADDR_LTIME, 32'h0000_0002);
        wr(`DCDM_ADDR_DTIME0, 32'h0000_0001);
        wr(`DCDM_ADDR_DBAND0, 32'h0000_0005);
        wr(`DCDM_ADDR_OFFS0, 32'h0000_FF9C);
        lfsr = nxt_lfsr(lfsr);
        base = {4'h0, lfsr[11:0]};
        ch_value[0] <= base;
        ch_value[1] <= base + 16'h0400;
        cyc(50);
        rd(`DCDM_ADDR_STATE, 33'h0, 33'h33);
        $display("test single done");
        wr(`DCDM_ADDR_CTRL, 32'h1);
        ch_value[1] <= base + 16'h0069;
        cyc(40);
        rd(`DCDM_ADDR_STATE, 33'h0, 33'h51);
        ch_value[1] <= base + 16'h006A;
        cyc(5);
        check(disc_fault[0], 1'b0);
        cyc(40);
        rd(`DCDM_ADDR_STATE, 33'h53, 33'h53);
        ch_value[1] <= base + 16'h0069;
        cyc(4);
        check(disc_fault[0], 1'b0);
        wr(`DCDM_ADDR_DTIME0, 32'h0000_0002);
        repeat (4)
        begin
            ch_value[1] <= base + 16'h006A;
            cyc(15);
            check(disc_fault[0], 1'b0);
            ch_value[1] <= base + 16'h0069;
            cyc(3);
        end
        wr(`DCDM_ADDR_DTIME0, 32'h0);
        ch_value[1] <= base + 16'h0200;
        cyc(60);
        check(disc_fault[0], 1'b0);
        $display("test equivalent done");
        ch_value[2] <= 16'h7FFF;
        ch_value[3] <= 16'h7FFF;
        wr(`DCDM_ADDR_OFFS1, 32'h0000_7FFF);
        wr(`DCDM_ADDR_CTRL, 32'h3);
        cyc(3);
        rd(`DCDM_ADDR_STATE, 33'h0, 33'h80);
        ch_value[1] <= base + 16'h0069;
        $display("test saturation done");
        wr(`DCDM_ADDR_MASK, 32'h10);
        cyc(40);
        rd(`DCDM_ADDR_STAT, 33'h0, 33'h0);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        chan_err[2] <= 1'b1;
        cyc(1);
        chan_err[2] <= 1'b0;
        cyc(3);
        check({err_latched[2], irq}, 2'b11);
        cyc(6);
        check(err_latched[2], 1'b1);
        cyc(30);
        check(err_latched[2], 1'b0);
        check(seen[2], 1'b1);
        rd(`DCDM_ADDR_STAT, 33'h10, 33'h10);
        cyc(2);
        check(irq, 1'b0);
        chan_err[3] <= 1'b1;
        cyc(1);
        chan_err[3] <= 1'b0;
        cyc(4);
        check(irq, 1'b0);
        $display("test latch done");
        tally_and_finish();
    end
endmodule : dual_channel_discrepancy_monitor_test
